// ==== rtl/dupc_ctrl.sv ====
// command decoder and display update sequencer of the panel driver
//
// How it works
// RULE1 - soft reset restores all command parameter defaults except deep sleep
// RULE2 - soft reset keeps the deep sleep setting
// RULE3 - soft reset leaves both frame memories untouched
// RULE4 - busy high while soft reset works
// RULE5 - activation runs stages picked by stage select
// RULE6 - busy high during whole update sequence
// RULE7 - host should not interrupt a running update
// RULE8 - memory option takes two bytes, red nibble high
// RULE9 - monochrome nibble: normal, forced zero, inverted
// RULE10 - stage select takes one byte, default ff
// RULE11 - stages run clock, analog, drive, analog, clock
// RULE12 - deep sleep holds busy until hardware reset
// RULE13 - red nibble uses the monochrome codes
// RULE14 - host sends commands dc low, data dc high
`timescale 1ns/10ps
module dupc_ctrl #(
   parameter int SWRESET_CYCLES = dupc_pkg::SWRESET_CYC,
   parameter int STAGE_CYCLES = dupc_pkg::STAGE_CYC,
   parameter int DRIVE_CYCLES = dupc_pkg::DRIVE_CYC
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic wr_strobe,
   input wire logic data_sel,
   input wire logic [7:0] wr_data,
   output logic busy,
   output logic [15:0] update_memory_option,
   output logic [7:0] update_stage_select,
   output logic [1:0] sleep_setting,
   output logic [1:0] plane_force_zero,
   output logic [1:0] plane_invert,
   output logic clock_enable,
   output logic analog_enable,
   output logic panel_drive,
   output logic drive_mode2
);
   dupc_pkg::dupc_state_t state, next_state;
   logic [dupc_pkg::CNT_W-1:0] cnt, next_cnt, stage_last;
   logic [7:0] cmd, next_cmd;
   logic [1:0] idx, next_idx;
   logic [7:0] opt_a, next_opt_a, stage_sel, next_stage_sel;
   logic opt_b7, next_opt_b7;
   logic [1:0] next_sleep_setting;
   logic next_clock_enable, next_analog_enable, next_panel_drive, next_drive_mode2;
   logic stage_on, stage_done;

   // busy follows any non idle state, deep sleep included
   assign busy = (state != dupc_pkg::DUPC_IDLE); // [RULE4] [RULE6] [RULE12]
   assign update_memory_option = {opt_b7, 7'h00, opt_a};
   assign update_stage_select = stage_sel;

   // length and enable of the current stage
   always_comb begin
      stage_on = 1'b1;
      stage_last = dupc_pkg::CNT_W'(STAGE_CYCLES - 1);
      unique case (state)
         dupc_pkg::DUPC_RESET: stage_last = dupc_pkg::CNT_W'(SWRESET_CYCLES - 1);
         dupc_pkg::DUPC_CLK_ON: stage_on = stage_sel[dupc_pkg::STG_CLK_ON];
         dupc_pkg::DUPC_ANA_ON: stage_on = stage_sel[dupc_pkg::STG_ANA_ON];
         dupc_pkg::DUPC_DRIVE: begin
            stage_on = stage_sel[dupc_pkg::STG_DRIVE];
            stage_last = dupc_pkg::CNT_W'(DRIVE_CYCLES - 1);
         end
         dupc_pkg::DUPC_ANA_OFF: stage_on = stage_sel[dupc_pkg::STG_ANA_OFF];
         dupc_pkg::DUPC_CLK_OFF: stage_on = stage_sel[dupc_pkg::STG_CLK_OFF];
         dupc_pkg::DUPC_IDLE, dupc_pkg::DUPC_SLEEP: stage_on = 1'b0;
      endcase
      stage_done = !stage_on || (cnt == stage_last);
   end

   // command decode, parameter capture and stage sequencing
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_cmd = cmd;
      next_idx = idx;
      next_opt_a = opt_a;
      next_opt_b7 = opt_b7;
      next_stage_sel = stage_sel;
      next_sleep_setting = sleep_setting;
      next_clock_enable = clock_enable;
      next_analog_enable = analog_enable;
      next_panel_drive = 1'b0;
      next_drive_mode2 = drive_mode2;
      unique case (state)
         dupc_pkg::DUPC_IDLE: begin
            // writes are taken only while idle
            if (wr_strobe && !data_sel) begin // [RULE14]
               next_cmd = wr_data;
               next_idx = 2'd0;
               next_cnt = '0;
               if (wr_data == dupc_pkg::CMD_SW_RESET) begin
                  // frame memories live outside and get no write here
                  next_state = dupc_pkg::DUPC_RESET; // [RULE3]
                  next_cmd = dupc_pkg::CMD_NONE;
                  next_opt_a = dupc_pkg::MEM_OPT_A_RST; // [RULE1]
                  next_opt_b7 = dupc_pkg::MEM_OPT_B_RST[dupc_pkg::MEM_OPT_B_BIT]; // [RULE1]
                  next_stage_sel = dupc_pkg::STAGE_SEL_RST; // [RULE1]
                  next_clock_enable = 1'b0; // [RULE1]
                  next_analog_enable = 1'b0; // [RULE1]
                  next_drive_mode2 = 1'b0; // [RULE1]
                  // sleep_setting intentionally held [RULE2]
               end else if (wr_data == dupc_pkg::CMD_ACTIVATE) begin
                  next_state = dupc_pkg::DUPC_CLK_ON; // [RULE5]
               end
            end else if (wr_strobe) begin
               next_idx = (idx == 2'd3) ? idx : idx + 2'd1;
               if (cmd == dupc_pkg::CMD_MEM_OPT && idx == 2'd0) begin
                  next_opt_a = wr_data; // [RULE8] [RULE9] [RULE13]
               end else if (cmd == dupc_pkg::CMD_MEM_OPT && idx == 2'd1) begin
                  next_opt_b7 = wr_data[dupc_pkg::MEM_OPT_B_BIT]; // [RULE8]
               end else if (cmd == dupc_pkg::CMD_STAGE_SEL && idx == 2'd0) begin
                  next_stage_sel = wr_data; // [RULE10]
               end else if (cmd == dupc_pkg::CMD_SLEEP && idx == 2'd0) begin
                  next_sleep_setting = wr_data[1:0];
                  if (wr_data[1:0] == dupc_pkg::SLEEP_ENTER) begin
                     next_state = dupc_pkg::DUPC_SLEEP; // [RULE12]
                  end
               end
            end
         end
         dupc_pkg::DUPC_SLEEP: begin
            next_state = dupc_pkg::DUPC_SLEEP; // [RULE12]
         end
         default: begin
            // a running sequence ignores the host entirely
            next_cnt = stage_done ? '0 : cnt + 1'b1; // [RULE7]
            if (state == dupc_pkg::DUPC_DRIVE && stage_on && !stage_done) begin
               next_panel_drive = 1'b1;
               next_drive_mode2 = stage_sel[dupc_pkg::STG_MODE2];
            end
            if (stage_done) begin
               unique case (state)
                  dupc_pkg::DUPC_RESET: next_state = dupc_pkg::DUPC_IDLE;
                  dupc_pkg::DUPC_CLK_ON: begin
                     next_state = dupc_pkg::DUPC_ANA_ON; // [RULE11]
                     if (stage_on) next_clock_enable = 1'b1;
                  end
                  dupc_pkg::DUPC_ANA_ON: begin
                     next_state = dupc_pkg::DUPC_DRIVE; // [RULE11]
                     if (stage_on) next_analog_enable = 1'b1;
                  end
                  dupc_pkg::DUPC_DRIVE: next_state = dupc_pkg::DUPC_ANA_OFF; // [RULE11]
                  dupc_pkg::DUPC_ANA_OFF: begin
                     next_state = dupc_pkg::DUPC_CLK_OFF; // [RULE11]
                     if (stage_on) next_analog_enable = 1'b0;
                  end
                  dupc_pkg::DUPC_CLK_OFF: begin
                     next_state = dupc_pkg::DUPC_IDLE;
                     if (stage_on) next_clock_enable = 1'b0;
                  end
                  default: next_state = dupc_pkg::DUPC_IDLE;
               endcase
            end
         end
      endcase
   end

   // registers of the decoder and sequencer
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= dupc_pkg::DUPC_IDLE;
         cnt <= '0;
         cmd <= dupc_pkg::CMD_NONE;
         idx <= 2'd0;
         opt_a <= dupc_pkg::MEM_OPT_A_RST;
         opt_b7 <= 1'b0;
         stage_sel <= dupc_pkg::STAGE_SEL_RST;
         sleep_setting <= dupc_pkg::SLEEP_RST;
         clock_enable <= 1'b0;
         analog_enable <= 1'b0;
         panel_drive <= 1'b0;
         drive_mode2 <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         cmd <= next_cmd;
         idx <= next_idx;
         opt_a <= next_opt_a;
         opt_b7 <= next_opt_b7;
         stage_sel <= next_stage_sel;
         sleep_setting <= next_sleep_setting;
         clock_enable <= next_clock_enable;
         analog_enable <= next_analog_enable;
         panel_drive <= next_panel_drive;
         drive_mode2 <= next_drive_mode2;
      end
   end

   // per plane decode of the memory handling nibble, plane 0 mono, plane 1 red
   for (genvar p = 0; p < 2; p++) begin : g_plane
      logic [3:0] code;
      logic next_zero, next_inv;
      assign code = opt_a[(p == 0 ? dupc_pkg::MONO_LSB : dupc_pkg::RED_LSB) +: 4];
      always_comb begin
         next_zero = (code == dupc_pkg::PLANE_ZERO); // [RULE9] [RULE13]
         next_inv = (code == dupc_pkg::PLANE_INVERT); // [RULE9] [RULE13]
      end
      always_ff @(posedge sys_clk or negedge arst_n) begin
         if (!arst_n) begin
            plane_force_zero[p] <= 1'b0;
            plane_invert[p] <= 1'b0;
         end else begin
            plane_force_zero[p] <= next_zero;
            plane_invert[p] <= next_inv;
         end
      end
   end

   // checks
   localparam int RST_WAIT = SWRESET_CYCLES; // longest wait for busy low after the first four busy cycles
   sequence s_reset_cmd;
      !busy && wr_strobe && !data_sel && wr_data == dupc_pkg::CMD_SW_RESET;
   endsequence
   sequence s_act_cmd;
      !busy && wr_strobe && !data_sel && wr_data == dupc_pkg::CMD_ACTIVATE;
   endsequence

   property p_reset_defaults;
      @(posedge sys_clk) disable iff (!arst_n)
      s_reset_cmd |=> opt_a == 8'h00 && !opt_b7 && stage_sel == 8'hff;
   endproperty
   a_reset_defaults: assert property (p_reset_defaults) else $error("soft reset left a parameter set"); // [RULE1]

   property p_reset_keeps_sleep;
      @(posedge sys_clk) disable iff (!arst_n)
      s_reset_cmd |=> sleep_setting == $past(sleep_setting);
   endproperty
   a_reset_keeps_sleep: assert property (p_reset_keeps_sleep) else $error("soft reset changed sleep"); // [RULE2]

   property p_reset_busy;
      @(posedge sys_clk) disable iff (!arst_n)
      s_reset_cmd |=> busy [*4] ##[0:RST_WAIT] !busy;
   endproperty
   a_reset_busy: assert property (p_reset_busy) else $error("busy wrong during soft reset"); // [RULE4]

   property p_act_start;
      @(posedge sys_clk) disable iff (!arst_n)
      s_act_cmd |=> state == dupc_pkg::DUPC_CLK_ON && busy;
   endproperty
   a_act_start: assert property (p_act_start) else $error("activation did not start"); // [RULE5]

   property p_busy_in_drive;
      @(posedge sys_clk) disable iff (!arst_n)
      panel_drive |-> busy && state == dupc_pkg::DUPC_DRIVE;
   endproperty
   a_busy_in_drive: assert property (p_busy_in_drive) else $error("drive without busy"); // [RULE6]

   property p_opt_write;
      @(posedge sys_clk) disable iff (!arst_n)
      !busy && wr_strobe && data_sel && cmd == dupc_pkg::CMD_MEM_OPT && idx == 2'd0
         |=> opt_a == $past(wr_data) ##1 plane_invert[1] == (opt_a[7:4] == 4'h8);
   endproperty
   a_opt_write: assert property (p_opt_write) else $error("memory option not taken"); // [RULE8]

   property p_mono_zero;
      @(posedge sys_clk) disable iff (!arst_n)
      ##1 plane_force_zero[0] == ($past(opt_a[3:0]) == 4'h4);
   endproperty
   a_mono_zero: assert property (p_mono_zero) else $error("mono zero decode wrong"); // [RULE9]

   property p_stage_write;
      @(posedge sys_clk) disable iff (!arst_n)
      !busy && wr_strobe && data_sel && cmd == dupc_pkg::CMD_STAGE_SEL && idx == 2'd0
         |=> stage_sel == $past(wr_data);
   endproperty
   a_stage_write: assert property (p_stage_write) else $error("stage select not taken"); // [RULE10]

   property p_order;
      @(posedge sys_clk) disable iff (!arst_n)
      state == dupc_pkg::DUPC_ANA_ON && $past(state) != dupc_pkg::DUPC_ANA_ON
         |-> $past(state) == dupc_pkg::DUPC_CLK_ON;
   endproperty
   a_order: assert property (p_order) else $error("stage order broken"); // [RULE11]

   property p_sleep_holds;
      @(posedge sys_clk) disable iff (!arst_n)
      state == dupc_pkg::DUPC_SLEEP |=> busy && state == dupc_pkg::DUPC_SLEEP;
   endproperty
   a_sleep_holds: assert property (p_sleep_holds) else $error("deep sleep left"); // [RULE12]
endmodule

// ==== rtl/dupc_pkg.sv ====
// constants shared by the display update command control block
package dupc_pkg;
   // command codes
   localparam logic [7:0] CMD_SLEEP = 8'h10;
   localparam logic [7:0] CMD_SW_RESET = 8'h12;
   localparam logic [7:0] CMD_ACTIVATE = 8'h20;
   localparam logic [7:0] CMD_MEM_OPT = 8'h21;
   localparam logic [7:0] CMD_STAGE_SEL = 8'h22;
   localparam logic [7:0] CMD_NONE = 8'h00;
   // reset values of the parameter registers, and the deep sleep entry code
   localparam logic [7:0] MEM_OPT_A_RST = 8'h00;
   localparam logic [7:0] MEM_OPT_B_RST = 8'h00;
   localparam logic [7:0] STAGE_SEL_RST = 8'hff;
   localparam logic [1:0] SLEEP_RST = 2'h0;
   localparam logic [1:0] SLEEP_ENTER = 2'h1;
   // field positions
   localparam int MEM_OPT_B_BIT = 7;
   localparam int MONO_LSB = 0;
   localparam int RED_LSB = 4;
   // memory handling codes, same for both planes
   localparam logic [3:0] PLANE_NORMAL = 4'h0;
   localparam logic [3:0] PLANE_ZERO = 4'h4;
   localparam logic [3:0] PLANE_INVERT = 4'h8;
   // stage select bits
   localparam int STG_CLK_ON = 7;
   localparam int STG_ANA_ON = 6;
   localparam int STG_MODE2 = 3;
   localparam int STG_DRIVE = 2;
   localparam int STG_ANA_OFF = 1;
   localparam int STG_CLK_OFF = 0;
   // timing
   localparam int CLK_PERIOD_PS = 25000;
   localparam int SWRESET_TIME_NS = 1000;
   localparam int STAGE_TIME_NS = 500;
   localparam int DRIVE_TIME_US = 100;
   localparam int SWRESET_CYC = (SWRESET_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int STAGE_CYC = (STAGE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int DRIVE_CYC = (DRIVE_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W = 13;
   typedef enum logic [2:0] {
      DUPC_IDLE, DUPC_RESET, DUPC_CLK_ON, DUPC_ANA_ON, DUPC_DRIVE, DUPC_ANA_OFF, DUPC_CLK_OFF, DUPC_SLEEP
   } dupc_state_t;
endpackage

// ==== sim/dupc_host.sv ====
// host side model that writes command and parameter bytes into the controller
`timescale 1ns/10ps
module dupc_host (
   input wire logic sys_clk,
   output logic wr_strobe,
   output logic data_sel,
   output logic [7:0] wr_data
);
   initial begin
      wr_strobe = 1'b0;
      data_sel = 1'b0;
      wr_data = 8'h00;
   end
   // one byte, strobe for one cycle; data turns over afterwards so a stale byte never looks valid
   task automatic put(input logic dc, input logic [7:0] b);
      @(posedge sys_clk);
      wr_strobe <= 1'b1;
      data_sel <= dc;
      wr_data <= b;
      @(posedge sys_clk);
      wr_strobe <= 1'b0;
      wr_data <= ~b;
   endtask
   // command byte with dc low, then n parameter bytes with dc high, low byte first
   task automatic cmd(input logic [7:0] c, input int n, input logic [15:0] p);
      put(1'b0, c);
      for (int i = 0; i < n; i++) begin
         put(1'b1, p[8*i +: 8]);
      end
   endtask
endmodule

// ==== sim/tb_display_update_command_control.sv ====
// self-checking bench for the display update command control block
`timescale 1ns/10ps
module tb_display_update_command_control;
   localparam int SWR = 4;
   localparam int STG = 2;
   localparam int DRV = 8;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic wr_strobe, data_sel, busy, clock_enable, analog_enable, panel_drive, drive_mode2;
   logic [7:0] wr_data, update_stage_select;
   logic [15:0] update_memory_option;
   logic [1:0] sleep_setting, plane_force_zero, plane_invert;
   int err_total = 0;
   int samples_checked = 0;
   int cyc = 0;
   int ev, drv_n;
   logic mode_seen, p_clk, p_ana, p_drv;
   bit m_clk = 0;
   bit m_ana = 0;
   logic [3:0] codes [3] = '{dupc_pkg::PLANE_NORMAL, dupc_pkg::PLANE_ZERO, dupc_pkg::PLANE_INVERT};
   always #12.5 sys_clk = ~sys_clk;
   dupc_host i_host (.sys_clk(sys_clk), .wr_strobe(wr_strobe), .data_sel(data_sel), .wr_data(wr_data));
   dupc_ctrl #(.SWRESET_CYCLES(SWR), .STAGE_CYCLES(STG), .DRIVE_CYCLES(DRV)) i_dut (
      .sys_clk(sys_clk), .arst_n(arst_n), .wr_strobe(wr_strobe), .data_sel(data_sel), .wr_data(wr_data),
      .busy(busy), .update_memory_option(update_memory_option), .update_stage_select(update_stage_select),
      .sleep_setting(sleep_setting), .plane_force_zero(plane_force_zero), .plane_invert(plane_invert),
      .clock_enable(clock_enable), .analog_enable(analog_enable), .panel_drive(panel_drive),
      .drive_mode2(drive_mode2));
   // records the order of stage edges as octal digits and watches the run time
   always @(posedge sys_clk) begin
      if (clock_enable === 1'b1 && p_clk !== 1'b1) ev = ev * 8 + 1;
      if (analog_enable === 1'b1 && p_ana !== 1'b1) ev = ev * 8 + 2;
      if (panel_drive === 1'b1 && p_drv !== 1'b1) ev = ev * 8 + 3;
      if (analog_enable === 1'b0 && p_ana === 1'b1) ev = ev * 8 + 4;
      if (clock_enable === 1'b0 && p_clk === 1'b1) ev = ev * 8 + 5;
      if (panel_drive === 1'b1) begin
         drv_n++;
         mode_seen = drive_mode2;
      end
      p_clk = clock_enable;
      p_ana = analog_enable;
      p_drv = panel_drive;
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         close_out();
      end
   end
   task automatic close_out();
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // counts busy cycles after the last byte; the host waits for busy low before writing again, except for the stage byte sent in deep sleep
   task automatic busy_len(output int n);
      n = 0;
      do begin
         @(posedge sys_clk);
         #1 n++;
      end while (busy === 1'b1 && n < 5000);
   endtask
   task automatic settle();
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   // one update with stage byte s, compared with the stage model
   task automatic run_update(input logic [7:0] s);
      int n, x_ev, x_n;
      x_ev = 0;
      i_host.cmd(dupc_pkg::CMD_STAGE_SEL, 1, {8'h00, s});
      settle();
      chk("stage_select", {24'h0, s}, {24'h0, update_stage_select});
      x_n = (s[7] ? STG : 1) + (s[6] ? STG : 1) + (s[2] ? DRV : 1) + (s[1] ? STG : 1) + (s[0] ? STG : 1);
      if (s[7] && !m_clk) x_ev = x_ev * 8 + 1;
      m_clk = m_clk | s[7];
      if (s[6] && !m_ana) x_ev = x_ev * 8 + 2;
      m_ana = m_ana | s[6];
      if (s[2]) x_ev = x_ev * 8 + 3;
      if (s[1] && m_ana) x_ev = x_ev * 8 + 4;
      m_ana = m_ana & !s[1];
      if (s[0] && m_clk) x_ev = x_ev * 8 + 5;
      m_clk = m_clk & !s[0];
      ev = 0;
      drv_n = 0;
      mode_seen = 1'b0;
      i_host.cmd(dupc_pkg::CMD_ACTIVATE, 0, 16'h0000);
      busy_len(n);
      // the monitor sees the last stage edge one clock after busy drops
      settle();
      chk("update_busy_cycles", x_n, n);
      chk("stage_order", x_ev, ev);
      chk("drive_cycles", s[2] ? DRV - 1 : 0, drv_n);
      chk("drive_mode", {31'h0, s[2] & s[3]}, {31'h0, mode_seen});
      chk("clock_enable", {31'h0, m_clk}, {31'h0, clock_enable});
      chk("analog_enable", {31'h0, m_ana}, {31'h0, analog_enable});
   endtask
   // main sequence
   initial begin
      int n;
      logic [7:0] a, b, st;
      void'($urandom(72131));
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'b1;
      #1 chk("option_por", 32'h0, {16'h0, update_memory_option});
      chk("stage_por", 32'hff, {24'h0, update_stage_select});
      // every pairing of plane codes, with a random second byte
      for (int i = 0; i < 9; i++) begin
         a = {codes[i / 3], codes[i % 3]};
         b = 8'($urandom);
         i_host.cmd(dupc_pkg::CMD_MEM_OPT, 2, {b, a});
         settle();
         chk("mem_option", {16'h0, b[7], 7'h00, a}, {16'h0, update_memory_option});
         chk("force_zero", {30'h0, codes[i / 3] == 4'h4, codes[i % 3] == 4'h4}, {30'h0, plane_force_zero});
         chk("invert", {30'h0, codes[i / 3] == 4'h8, codes[i % 3] == 4'h8}, {30'h0, plane_invert});
      end
      run_update(8'hff);
      run_update(8'hf7);
      run_update(8'h80);
      i_host.cmd(dupc_pkg::CMD_SLEEP, 1, 16'h0002);
      i_host.cmd(dupc_pkg::CMD_SW_RESET, 0, 16'h0000);
      busy_len(n);
      chk("reset_busy_cycles", SWR, n);
      chk("option_after_reset", 32'h0, {16'h0, update_memory_option});
      chk("stage_after_reset", 32'hff, {24'h0, update_stage_select});
      chk("clock_after_reset", 32'h0, {31'h0, clock_enable});
      chk("sleep_kept", 32'h2, {30'h0, sleep_setting});
      m_clk = 0;
      m_ana = 0;
      st = 8'($urandom);
      run_update(st);
      i_host.cmd(dupc_pkg::CMD_SLEEP, 1, 16'h0001);
      i_host.cmd(dupc_pkg::CMD_STAGE_SEL, 1, {8'h00, ~st});
      repeat (40) @(posedge sys_clk);
      #1 chk("sleep_busy", 32'h1, {31'h0, busy});
      chk("sleep_refuses", {24'h0, st}, {24'h0, update_stage_select});
      @(posedge sys_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'b1;
      #1 chk("wake_busy", 32'h0, {31'h0, busy});
      chk("wake_sleep", 32'h0, {30'h0, sleep_setting});
      chk("wake_stage", 32'hff, {24'h0, update_stage_select});
      close_out();
   end
endmodule
